/* hw/fsfb_top.sv */
// Sticky rail fault and critical temperature flags behind an AHB-Lite slave
//
// Overview of operation
// - A loss of regulation on aux LDO two, switch A1 or step-down rails six to one sets bits 7..0 of the low register.
// - A loss of regulation on aux LDO one, termination LDO, switch B2, B1 or aux LDO three sets bits 4..0 of the high register.
// - A set fault flag stays one until the host writes one to its bit, which clears it.
// - Reset clears all three flag registers to zero.
// - Each of five temperature sensors sets its own flag once it passes the critical threshold.
// - Temperature bits 4..0 are rest of die, termination LDO, upper right, upper left and lower right.
// - A temperature flag reads one while asserted and clears on reset or when the host writes one to it.
`timescale 1ns/1ns
`default_nettype none
`include "fsfb_defs.svh"

module fsfb_top
	import fsfb_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [`FSFB_LOW_W-1:0] rail_fault_low_i,
	input wire logic [`FSFB_HIGH_W-1:0] rail_fault_high_i,
	input wire logic [`FSFB_TEMP_W-1:0] overtemp_i,
	output logic irq_o
);

	// ----------------------------------------
	// State and helpers
	// ----------------------------------------
	fsfb_state_t st_ff;
	fsfb_state_t nxt_st;
	logic [`FSFB_SYNC_W-1:0] ev;
	logic [`FSFB_LOW_W-1:0] ev_low;
	logic [`FSFB_HIGH_W-1:0] ev_high;
	logic [`FSFB_TEMP_W-1:0] ev_temp;
	logic [`FSFB_LOW_W-1:0] clr_low;
	logic [`FSFB_HIGH_W-1:0] clr_high;
	logic [`FSFB_TEMP_W-1:0] clr_temp;
	logic addr_take;
	logic [9:0] addr_idx;

	// Word read mux, unmapped indices read zero
	function automatic logic [31:0] rd_word(input logic [9:0] idx, input fsfb_state_t s);
		logic [31:0] w;
		w = 32'h00000000;
		case (idx)
			`FSFB_IDX_LOW: w[`FSFB_LOW_W-1:0] = s.flag_low;
			`FSFB_IDX_HIGH: w[`FSFB_HIGH_W-1:0] = s.flag_high;
			`FSFB_IDX_TEMP: w[`FSFB_TEMP_W-1:0] = s.flag_temp;
			`FSFB_IDX_MASK_LOW: w[`FSFB_LOW_W-1:0] = s.mask_low;
			`FSFB_IDX_MASK_HIGH: w[`FSFB_HIGH_W-1:0] = s.mask_high;
			`FSFB_IDX_MASK_TEMP: w[`FSFB_TEMP_W-1:0] = s.mask_temp;
			default: w = 32'h00000000;
		endcase
		return w;
	endfunction

	// Monitor event counts once second and third stages agree high
	assign ev = st_ff.sync_b & st_ff.sync_c;
	assign ev_low = ev[`FSFB_LOW_W-1:0];
	assign ev_high = ev[`FSFB_LOW_W+`FSFB_HIGH_W-1:`FSFB_LOW_W];
	assign ev_temp = ev[`FSFB_SYNC_W-1:`FSFB_LOW_W+`FSFB_HIGH_W];

	// Write-one-to-clear strobes, only in a write data phase
	assign clr_low = (st_ff.wr_pend && st_ff.wr_idx == `FSFB_IDX_LOW) ? hwdata_i[`FSFB_LOW_W-1:0] : '0;
	assign clr_high = (st_ff.wr_pend && st_ff.wr_idx == `FSFB_IDX_HIGH) ? hwdata_i[`FSFB_HIGH_W-1:0] : '0;
	assign clr_temp = (st_ff.wr_pend && st_ff.wr_idx == `FSFB_IDX_TEMP) ? hwdata_i[`FSFB_TEMP_W-1:0] : '0;

	// Address phase accepted
	assign addr_take = hsel_i && hready_i && htrans_i == `FSFB_HTRANS_NONSEQ;
	assign addr_idx = haddr_i[11:2];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		// Three stage capture of the analog monitor pulses
		nxt_st.sync_a = {overtemp_i, rail_fault_high_i, rail_fault_low_i};
		nxt_st.sync_b = st_ff.sync_a;
		nxt_st.sync_c = st_ff.sync_b;
		// zero bits in the write leave flags alone
		nxt_st.flag_low = (st_ff.flag_low & ~clr_low) | ev_low;
		nxt_st.flag_high = (st_ff.flag_high & ~clr_high) | ev_high;
		nxt_st.flag_temp = (st_ff.flag_temp & ~clr_temp) | ev_temp;
		// Mask writes, only the implemented low bits are kept
		if (st_ff.wr_pend) begin
			case (st_ff.wr_idx)
				`FSFB_IDX_MASK_LOW: nxt_st.mask_low = hwdata_i[`FSFB_LOW_W-1:0];
				`FSFB_IDX_MASK_HIGH: nxt_st.mask_high = hwdata_i[`FSFB_HIGH_W-1:0];
				`FSFB_IDX_MASK_TEMP: nxt_st.mask_temp = hwdata_i[`FSFB_TEMP_W-1:0];
				default: nxt_st.wr_idx = st_ff.wr_idx;
			endcase
		end
		// Address phase: writes are applied in the data phase
		nxt_st.wr_pend = addr_take && hwrite_i && hsize_i == `FSFB_HSIZE_WORD;
		nxt_st.wr_idx = addr_take ? addr_idx : st_ff.wr_idx;
		// Read data from the updated flags, so a read right after a clear sees it
		// reserved bits read zero
		nxt_st.rdata = (addr_take && !hwrite_i) ? rd_word(addr_idx, nxt_st) : 32'h00000000;
		// Zero wait states, response always OKAY
		nxt_st.ready = 1'b1;
		nxt_st.resp = 1'b0;
		// Level interrupt while any unmasked flag stands
		nxt_st.irq = |{nxt_st.flag_low & nxt_st.mask_low, nxt_st.flag_high & nxt_st.mask_high,
			nxt_st.flag_temp & nxt_st.mask_temp};
		if (reset_i) begin
			nxt_st.sync_a = `FSFB_RST_SYNC;
			nxt_st.sync_b = `FSFB_RST_SYNC;
			nxt_st.sync_c = `FSFB_RST_SYNC;
			nxt_st.flag_low = `FSFB_RST_LOW;
			nxt_st.flag_high = `FSFB_RST_HIGH;
			nxt_st.flag_temp = `FSFB_RST_TEMP;
			nxt_st.mask_low = `FSFB_RST_LOW;
			nxt_st.mask_high = `FSFB_RST_HIGH;
			nxt_st.mask_temp = `FSFB_RST_TEMP;
			nxt_st.wr_pend = 1'b0;
			nxt_st.wr_idx = 10'h000;
			nxt_st.rdata = 32'h00000000;
			nxt_st.ready = 1'b0;
			nxt_st.resp = 1'b0;
			nxt_st.irq = 1'b0;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		st_ff <= nxt_st;
	end

	// Outputs straight from the state flops
	assign hrdata_o = st_ff.rdata;
	assign hreadyout_o = st_ff.ready;
	assign hresp_o = st_ff.resp; // Kept in a flop like every other output
	assign irq_o = st_ff.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_low0_held;
		rail_fault_low_i[0] [*4];
	endsequence

	sequence s_temp4_held;
		overtemp_i[4] [*4];
	endsequence

	sequence s_high4_held;
		rail_fault_high_i[4] [*4];
	endsequence

	sequence s_temp0_held;
		overtemp_i[0] [*4];
	endsequence

	// Reset seen high, then low at the next edge
	sequence s_reset_release;
		reset_i ##1 !reset_i;
	endsequence

	property p_low_pin_sets;
		@(posedge clock_i) disable iff (reset_i)
		s_low0_held |=> st_ff.flag_low[0];
	endproperty
	a_low_pin_sets: assert property (p_low_pin_sets) else $error("low fault pin did not set flag");

	property p_high_event_sets;
		@(posedge clock_i) disable iff (reset_i)
		(ev_high != '0) |=> ((st_ff.flag_high & $past(ev_high)) == $past(ev_high));
	endproperty
	a_high_event_sets: assert property (p_high_event_sets) else $error("high fault event lost");

	property p_low_sticky;
		@(posedge clock_i) disable iff (reset_i)
		(st_ff.flag_low != '0) |=> ((st_ff.flag_low & $past(st_ff.flag_low & ~clr_low))
			== $past(st_ff.flag_low & ~clr_low));
	endproperty
	a_low_sticky: assert property (p_low_sticky) else $error("low flag dropped without clear");

	property p_low_clear;
		@(posedge clock_i) disable iff (reset_i)
		((clr_low & ~ev_low) != '0) |=> ((st_ff.flag_low & $past(clr_low & ~ev_low)) == '0);
	endproperty
	a_low_clear: assert property (p_low_clear) else $error("write one did not clear low flag");

	property p_reset_zero;
		@(posedge clock_i)
		reset_i |=> (st_ff.flag_low == '0 && st_ff.flag_high == '0 && st_ff.flag_temp == '0);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset");

	property p_temp_pin_sets;
		@(posedge clock_i) disable iff (reset_i)
		s_temp4_held |=> st_ff.flag_temp[4];
	endproperty
	a_temp_pin_sets: assert property (p_temp_pin_sets) else $error("die sensor did not set flag");

	property p_temp_clear;
		@(posedge clock_i) disable iff (reset_i)
		((clr_temp & ~ev_temp) != '0) |=> ((st_ff.flag_temp & $past(clr_temp & ~ev_temp)) == '0);
	endproperty
	a_temp_clear: assert property (p_temp_clear) else $error("write one did not clear temp flag");

	property p_temp_hold;
		@(posedge clock_i) disable iff (reset_i)
		(st_ff.flag_temp[0] && !clr_temp[0]) |=> st_ff.flag_temp[0];
	endproperty
	a_temp_hold: assert property (p_temp_hold) else $error("temp flag dropped without clear");

	property p_reserved_zero;
		@(posedge clock_i) disable iff (reset_i)
		(addr_take && !hwrite_i && addr_idx == `FSFB_IDX_HIGH) |=> (hrdata_o[31:`FSFB_HIGH_W] == '0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

	// Interrupt follows masks
	property p_irq_level;
		@(posedge clock_i) disable iff (reset_i)
		##1 irq_o == |{st_ff.flag_low & st_ff.mask_low, st_ff.flag_high & st_ff.mask_high,
			st_ff.flag_temp & st_ff.mask_temp};
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq does not follow masked flags");

	property p_low_event_sets;
		@(posedge clock_i) disable iff (reset_i)
		(ev_low != '0) |=> ((st_ff.flag_low & $past(ev_low)) == $past(ev_low));
	endproperty
	a_low_event_sets: assert property (p_low_event_sets) else $error("low fault event lost");

	property p_high_pin_sets;
		@(posedge clock_i) disable iff (reset_i)
		s_high4_held |=> st_ff.flag_high[4];
	endproperty
	a_high_pin_sets: assert property (p_high_pin_sets) else $error("high fault pin did not set flag");

	property p_high_sticky;
		@(posedge clock_i) disable iff (reset_i)
		(st_ff.flag_high != '0) |=> ((st_ff.flag_high & $past(st_ff.flag_high & ~clr_high))
			== $past(st_ff.flag_high & ~clr_high));
	endproperty
	a_high_sticky: assert property (p_high_sticky) else $error("high flag dropped without clear");

	property p_high_clear;
		@(posedge clock_i) disable iff (reset_i)
		((clr_high & ~ev_high) != '0) |=> ((st_ff.flag_high & $past(clr_high & ~ev_high)) == '0);
	endproperty
	a_high_clear: assert property (p_high_clear) else $error("write one did not clear high flag");

	property p_temp_corner_sets;
		@(posedge clock_i) disable iff (reset_i)
		s_temp0_held |=> st_ff.flag_temp[0];
	endproperty
	a_temp_corner_sets: assert property (p_temp_corner_sets) else $error("corner sensor did not set flag");

	property p_temp_reserved_zero;
		@(posedge clock_i) disable iff (reset_i)
		(addr_take && !hwrite_i && addr_idx == `FSFB_IDX_TEMP) |=> (hrdata_o[31:`FSFB_TEMP_W] == '0);
	endproperty
	a_temp_reserved_zero: assert property (p_temp_reserved_zero) else $error("temp reserved bits nonzero");

	// Ready one edge after release
	property p_ready_after_reset;
		@(posedge clock_i)
		s_reset_release |=> hreadyout_o;
	endproperty
	a_ready_after_reset: assert property (p_ready_after_reset) else $error("ready low after reset release");

	// Idle read data is zero
	property p_rdata_idle_zero;
		@(posedge clock_i) disable iff (reset_i)
		!(addr_take && !hwrite_i) |=> (hrdata_o == 32'h00000000);
	endproperty
	a_rdata_idle_zero: assert property (p_rdata_idle_zero) else $error("read data nonzero outside a read");

	// Response always okay
	property p_resp_okay;
		@(posedge clock_i) disable iff (reset_i)
		!hresp_o;
	endproperty
	a_resp_okay: assert property (p_resp_okay) else $error("error response driven");

	// Mask write lands
	property p_mask_temp_write;
		@(posedge clock_i) disable iff (reset_i)
		(st_ff.wr_pend && st_ff.wr_idx == `FSFB_IDX_MASK_TEMP) |=> (st_ff.mask_temp == $past(hwdata_i[`FSFB_TEMP_W-1:0]));
	endproperty
	a_mask_temp_write: assert property (p_mask_temp_write) else $error("temp mask write lost");

endmodule
`default_nettype wire

/* hw/fsfb_defs.svh */
// Constants of the fault status flag bank
`ifndef FSFB_DEFS_SVH
`define FSFB_DEFS_SVH

// ----------------------------------------
// Flag group widths
// ----------------------------------------
`define FSFB_LOW_W 8
`define FSFB_HIGH_W 5
`define FSFB_TEMP_W 5
`define FSFB_SYNC_W 18

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define FSFB_IDX_LOW 10'h0b2
`define FSFB_IDX_HIGH 10'h0b3
`define FSFB_IDX_TEMP 10'h0b4
`define FSFB_IDX_MASK_LOW 10'h0c0
`define FSFB_IDX_MASK_HIGH 10'h0c1
`define FSFB_IDX_MASK_TEMP 10'h0c2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FSFB_RST_LOW 8'h00
`define FSFB_RST_HIGH 5'h00
`define FSFB_RST_TEMP 5'h00
`define FSFB_RST_SYNC 18'h00000

// ----------------------------------------
// Bus encodings
// ----------------------------------------
`define FSFB_HSIZE_WORD 3'h2
`define FSFB_HTRANS_NONSEQ 2'h2

`endif

/* hw/fsfb_pkg.sv */
// Types of the fault status flag bank
`default_nettype none
`include "fsfb_defs.svh"

package fsfb_pkg;

	// Whole state of the bank
	typedef struct packed {
		logic [`FSFB_SYNC_W-1:0] sync_a;
		logic [`FSFB_SYNC_W-1:0] sync_b;
		logic [`FSFB_SYNC_W-1:0] sync_c;
		logic [`FSFB_LOW_W-1:0] flag_low;
		logic [`FSFB_HIGH_W-1:0] flag_high;
		logic [`FSFB_TEMP_W-1:0] flag_temp;
		logic [`FSFB_LOW_W-1:0] mask_low;
		logic [`FSFB_HIGH_W-1:0] mask_high;
		logic [`FSFB_TEMP_W-1:0] mask_temp;
		logic wr_pend;
		logic [9:0] wr_idx;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		logic irq;
	} fsfb_state_t;

endpackage
`default_nettype wire

/* test/fsfb_testbench.sv */
// Self-checking bench for the fault status flag bank over AHB-Lite
`timescale 1ns/1ns
`default_nettype none
`include "fsfb_defs.svh"

module testbench;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	logic [7:0] low_in = 8'h00;
	logic [4:0] high_in = 5'h00;
	logic [4:0] temp_in = 5'h00;
	int fails = 0;
	int checks = 0;
	logic [31:0] rd;
	logic [31:0] addr_tab [0:2];
	int width_tab [0:2];

	// ----------------------------------------
	// Clock, device
	// ----------------------------------------
	always #10 clock_i = ~clock_i;

	fsfb_top dut (.clock_i(clock_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
		.hreadyout_o(hreadyout), .hresp_o(hresp), .rail_fault_low_i(low_in), .rail_fault_high_i(high_in),
		.overtemp_i(temp_in), .irq_o(irq));

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	// Samples hready at each falling edge, then waits for the rising edge, until hready is high; read data is taken at that falling edge
	task automatic wait_ready(output logic [31:0] data);
		int n;
		logic ok;
		n = 0;
		do begin
			@(negedge clock_i);
			ok = (hreadyout === 1'b1);
			data = hrdata;
			@(posedge clock_i);
			n++;
		end while (!ok && n < 100);
		if (!ok) begin
			fails++;
		end
	endtask

	task automatic xfer(input logic [31:0] a, input logic wr, input logic [2:0] sz, input logic [31:0] d);
		logic [31:0] dummy;
		@(posedge clock_i);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= `FSFB_HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= sz;
		wait_ready(dummy);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wr ? d : 32'h00000000;
		wait_ready(rd);
	endtask

	task automatic wr32(input logic [31:0] a, input logic [31:0] d);
		xfer(a, 1'b1, `FSFB_HSIZE_WORD, d);
	endtask

	task automatic rd_check(input string name, input logic [31:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, `FSFB_HSIZE_WORD, 32'h00000000);
		check(name, rd, exp);
	endtask

	// Holds a monitor level long enough for the capture flops, then drops it
	task automatic raise(input int k, input logic [7:0] v);
		@(posedge clock_i);
		if (k == 0) low_in <= v;
		else if (k == 1) high_in <= v[4:0];
		else temp_in <= v[4:0];
		repeat (6) @(posedge clock_i);
		low_in <= 8'h00;
		high_in <= 5'h00;
		temp_in <= 5'h00;
		repeat (3) @(posedge clock_i);
	endtask

	task automatic results;
		if (fails == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		addr_tab[0] = {20'h00000, `FSFB_IDX_LOW, 2'b00};
		addr_tab[1] = {20'h00000, `FSFB_IDX_HIGH, 2'b00};
		addr_tab[2] = {20'h00000, `FSFB_IDX_TEMP, 2'b00};
		width_tab[0] = 8;
		width_tab[1] = 5;
		width_tab[2] = 5;
		repeat (3) @(posedge clock_i);
		reset_i <= 1'b0;
		for (int k = 0; k < 3; k++) rd_check("reset flags", addr_tab[k], 32'h00000000);
		rd_check("reset mask", {20'h00000, `FSFB_IDX_MASK_LOW, 2'b00}, 32'h00000000);
		rd_check("unmapped", 32'h00000100, 32'h00000000);
		// Each bit on its own pin; neighbour survives a one-bit clear
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < width_tab[k]; i++) begin
				int j;
				j = (i + 1) % width_tab[k];
				raise(k, 8'h01 << i);
				rd_check("flag set", addr_tab[k], 32'h00000001 << i);
				raise(k, 8'h01 << j);
				wr32(addr_tab[k], 32'h00000000);
				rd_check("zero write", addr_tab[k], (32'h1 << i) | (32'h1 << j));
				xfer(32'h00000100, 1'b1, `FSFB_HSIZE_WORD, 32'h000000ff);
				rd_check("unmapped write", addr_tab[k], (32'h1 << i) | (32'h1 << j));
				wr32(addr_tab[k], 32'h00000001 << i);
				rd_check("one clear", addr_tab[k], 32'h00000001 << j);
				wr32(addr_tab[k], 32'hffffffff);
				rd_check("all clear", addr_tab[k], 32'h00000000);
			end
		end
		// Reserved bits of the high and temperature registers stay zero with all their sources active
		raise(1, 8'hff);
		rd_check("high reserved", addr_tab[1], 32'h0000001f);
		raise(2, 8'hff);
		rd_check("temp reserved", addr_tab[2], 32'h0000001f);
		@(negedge clock_i);
		check("irq unmasked off", {31'h0, irq}, 32'h0);
		// Interrupt raised, masked, cleared
		wr32({20'h00000, `FSFB_IDX_MASK_TEMP, 2'b00}, 32'h00000004);
		@(negedge clock_i);
		check("irq on", {31'h0, irq}, 32'h1);
		wr32({20'h00000, `FSFB_IDX_MASK_TEMP, 2'b00}, 32'h00000000);
		@(negedge clock_i);
		check("irq masked", {31'h0, irq}, 32'h0);
		wr32({20'h00000, `FSFB_IDX_MASK_TEMP, 2'b00}, 32'h00000004);
		wr32(addr_tab[2], 32'h00000004);
		@(negedge clock_i);
		check("irq cleared", {31'h0, irq}, 32'h0);
		rd_check("temp left", addr_tab[2], 32'h0000001b);
		// Wide mask writes keep only the implemented bits
		wr32({20'h00000, `FSFB_IDX_MASK_LOW, 2'b00}, 32'hffffffff);
		rd_check("mask low", {20'h00000, `FSFB_IDX_MASK_LOW, 2'b00}, 32'h000000ff);
		wr32({20'h00000, `FSFB_IDX_MASK_HIGH, 2'b00}, 32'hffffffff);
		rd_check("mask high", {20'h00000, `FSFB_IDX_MASK_HIGH, 2'b00}, 32'h0000001f);
		@(negedge clock_i);
		check("irq high flags", {31'h0, irq}, 32'h1);
		// Reset in mid-run clears flags, masks and the interrupt
		raise(0, 8'hff);
		rd_check("low all", addr_tab[0], 32'h000000ff);
		@(posedge clock_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		reset_i <= 1'b0;
		for (int k = 0; k < 3; k++) rd_check("mid reset flags", addr_tab[k], 32'h00000000);
		rd_check("mid reset mask", {20'h00000, `FSFB_IDX_MASK_HIGH, 2'b00}, 32'h00000000);
		@(negedge clock_i);
		check("irq after reset", {31'h0, irq}, 32'h0);
		check("hresp", {31'h0, hresp}, 32'h0);
		results();
	end

	// Hang guard well beyond the expected run
	initial begin
		#200000;
		fails++;
		results();
	end
endmodule
`default_nettype wire
